// >>> serial_enable_irq.sv
// Purpose : enable and interrupt-gating slice of a fifo serial port,
//           with its status flags, on an ahb-lite register slave
// Assumes : single-word transfers; flag sets are one-cycle pulses from
//           the receiver; tx fifo and shifters live outside
// Notes   : zero wait states, response always okay
//
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps

// =====================================================================
// serial port control slice
// =====================================================================
// Functional notes
// RULE_01 - receive-data request needs rx_irq_on and trigger or idle-data flag
// RULE_02 - fault request when fault flag set and either receive enable on
// RULE_03 - break request on break or overrun flag, enabled by either bit
// RULE_04 - receive-data request drops on read-then-clear or rx_irq_on off
// RULE_05 - fault and break requests drop on flag clear or both enables off
// RULE_06 - rx_fault_irq_on still enables fault and break when rx_irq_on is 0
// RULE_07 - tx_on zero disables transmitter, one enables it
// RULE_08 - transmission starts only after data written to the tx fifo port
// RULE_09 - software sets transmit format and resets tx fifo before tx_on
// RULE_10 - rx_on zero disables receiver, one enables it
// RULE_11 - clearing rx_on leaves every receive status flag unchanged
// RULE_12 - reception starts on start bit, or on serial clock in sync mode
// RULE_13 - software sets receive format and resets rx fifo before rx_on
// RULE_14 - reserved control bit 2 reads zero; software writes zero
// RULE_15 - writing one never sets a flag; zero clears only after a set read
// RULE_16 - each request is a level held while flag and enable both hold
module serial_enable_irq (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   // ahb-lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // flag events from the receiver
   input  wire logic        rx_idle_data_set_i,
   input  wire logic        rx_fifo_trigger_set_i,
   input  wire logic        line_break_set_i,
   input  wire logic        rx_fault_set_i,
   input  wire logic        rx_overrun_set_i,
   input  wire logic        framing_fault_flag_i,
   input  wire logic        parity_fault_flag_i,
   // receiver line events
   input  wire logic        sync_mode_i,
   input  wire logic        rx_start_bit_i,
   input  wire logic        rx_sclk_seen_i,
   // enables and start strobes
   output logic             tx_on_o,
   output logic             rx_on_o,
   output logic             tx_start_o,
   output logic      [7:0]  tx_data_o,
   output logic             rx_start_o,
   // interrupt requests
   output logic             rx_full_irq_o,
   output logic             rx_fault_irq_o,
   output logic             line_break_irq_o,
   output logic             irq_o
);
   serial_ctl_pkg::ctl_state_t s_q;
   serial_ctl_pkg::ctl_state_t s_d;

   logic [serial_ctl_pkg::NUM_FLAGS-1:0] flag_set;
   logic [serial_ctl_pkg::NUM_FLAGS-1:0] flag_rd;
   logic [serial_ctl_pkg::NUM_FLAGS-1:0] flag_clr;
   logic [serial_ctl_pkg::NUM_FLAGS-1:0] flags;
   logic [serial_ctl_pkg::NUM_IRQ-1:0]   req;
   logic                                 addr_ph;
   logic                                 rd_ph;
   logic                                 rd_status;
   logic                                 rd_line;
   logic                                 wr_status;
   logic                                 wr_line;
   logic                                 fault_en;
   logic [31:0]                          rd_word;

   // ==================================================================
   // bus decode
   // ==================================================================
   // address phase taken when selected with htrans active and the bus ready; writes act in the
   // following data phase, reads load hrdata at the address phase edge
   assign addr_ph   = hsel_i && htrans_i[serial_ctl_pkg::HTRANS_ACTIVE_BIT]
                      && hready_i;
   assign rd_ph     = addr_ph && !hwrite_i;
   assign rd_status = rd_ph && (haddr_i[7:0] == serial_ctl_pkg::STATUS_OFS);
   assign rd_line   = rd_ph && (haddr_i[7:0] == serial_ctl_pkg::LINE_OFS);
   assign wr_status = s_q.wr_pend
                      && (s_q.addr == serial_ctl_pkg::STATUS_OFS);
   assign wr_line   = s_q.wr_pend && (s_q.addr == serial_ctl_pkg::LINE_OFS);

   // ==================================================================
   // receive status flags
   // ==================================================================
   // writing rx_on never reaches these cells, so flags survive it
   assign flag_set[serial_ctl_pkg::F_IDLE]    = rx_idle_data_set_i;
   assign flag_set[serial_ctl_pkg::F_TRIG]    = rx_fifo_trigger_set_i;
   assign flag_set[serial_ctl_pkg::F_BREAK]   = line_break_set_i;
   assign flag_set[serial_ctl_pkg::F_FAULT]   = rx_fault_set_i;
   assign flag_set[serial_ctl_pkg::F_OVERRUN] = rx_overrun_set_i; // RULE_11

   // clear only on a written zero; a written one does nothing
   always_comb begin
      flag_rd  = {rd_line, {4{rd_status}}};
      flag_clr = '0;
      flag_clr[serial_ctl_pkg::F_IDLE]    = wr_status
         && !hwdata_i[serial_ctl_pkg::IDLE_DATA_BIT];             // RULE_15
      flag_clr[serial_ctl_pkg::F_TRIG]    = wr_status
         && !hwdata_i[serial_ctl_pkg::TRIGGER_BIT];
      flag_clr[serial_ctl_pkg::F_BREAK]   = wr_status
         && !hwdata_i[serial_ctl_pkg::BREAK_BIT];
      flag_clr[serial_ctl_pkg::F_FAULT]   = wr_status
         && !hwdata_i[serial_ctl_pkg::FAULT_BIT];
      flag_clr[serial_ctl_pkg::F_OVERRUN] = wr_line
         && !hwdata_i[serial_ctl_pkg::OVERRUN_BIT];
   end

   for (genvar i = 0; i < serial_ctl_pkg::NUM_FLAGS; i++) begin : g_flag
      serial_flag_cell u_flag (
         .core_clk_i (core_clk_i),
         .rst_n_i    (rst_n_i),
         .set_i      (flag_set[i]),
         .rd_i       (flag_rd[i]),
         .clr_i      (flag_clr[i]),
         .flag_o     (flags[i])
      );
   end

   // ==================================================================
   // interrupt requests
   // ==================================================================
   // pure levels from registered state: they follow flags and enables
   assign fault_en = s_q.ctrl.rx_irq_on || s_q.ctrl.rx_fault_irq_on; // RULE_06
   assign req[serial_ctl_pkg::IRQ_RX_FULL] = s_q.ctrl.rx_irq_on
      && (flags[serial_ctl_pkg::F_TRIG] || flags[serial_ctl_pkg::F_IDLE]);
   // RULE_01 RULE_04 RULE_16
   assign req[serial_ctl_pkg::IRQ_RX_FAULT] = fault_en
      && flags[serial_ctl_pkg::F_FAULT];                    // RULE_02 RULE_05
   assign req[serial_ctl_pkg::IRQ_BREAK] = fault_en
      && (flags[serial_ctl_pkg::F_BREAK]
          || flags[serial_ctl_pkg::F_OVERRUN]);             // RULE_03 RULE_05
   assign rx_full_irq_o    = req[serial_ctl_pkg::IRQ_RX_FULL];
   assign rx_fault_irq_o   = req[serial_ctl_pkg::IRQ_RX_FAULT];
   assign line_break_irq_o = req[serial_ctl_pkg::IRQ_BREAK];
   assign irq_o            = |(s_q.irq_sts & s_q.irq_msk);

   // ==================================================================
   // read data
   // ==================================================================
   // unmapped offsets and the write-only tx port read as zero
   always_comb begin
      rd_word = '0;
      unique case (haddr_i[7:0])
         serial_ctl_pkg::CTRL_OFS: begin
            rd_word[serial_ctl_pkg::RX_IRQ_ON_BIT]       = s_q.ctrl.rx_irq_on;
            rd_word[serial_ctl_pkg::TX_ON_BIT]           = s_q.ctrl.tx_on;
            rd_word[serial_ctl_pkg::RX_ON_BIT]           = s_q.ctrl.rx_on;
            rd_word[serial_ctl_pkg::RX_FAULT_IRQ_ON_BIT] =
               s_q.ctrl.rx_fault_irq_on;
            rd_word[serial_ctl_pkg::CTRL_RSVD_BIT]       = 1'b0; // RULE_14
         end
         serial_ctl_pkg::STATUS_OFS: begin
            rd_word[serial_ctl_pkg::FAULT_BIT]     =
               flags[serial_ctl_pkg::F_FAULT];
            rd_word[serial_ctl_pkg::BREAK_BIT]     =
               flags[serial_ctl_pkg::F_BREAK];
            rd_word[serial_ctl_pkg::FRAMING_BIT]   = framing_fault_flag_i;
            rd_word[serial_ctl_pkg::PARITY_BIT]    = parity_fault_flag_i;
            rd_word[serial_ctl_pkg::TRIGGER_BIT]   =
               flags[serial_ctl_pkg::F_TRIG];
            rd_word[serial_ctl_pkg::IDLE_DATA_BIT] =
               flags[serial_ctl_pkg::F_IDLE];
         end
         serial_ctl_pkg::LINE_OFS: begin
            rd_word[serial_ctl_pkg::OVERRUN_BIT] =
               flags[serial_ctl_pkg::F_OVERRUN];
         end
         serial_ctl_pkg::IRQ_STS_OFS: begin
            rd_word[serial_ctl_pkg::NUM_IRQ-1:0] = s_q.irq_sts;
         end
         serial_ctl_pkg::IRQ_MSK_OFS: begin
            rd_word[serial_ctl_pkg::NUM_IRQ-1:0] = s_q.irq_msk;
         end
         default: begin
            rd_word = '0;
         end
      endcase
   end

   // ==================================================================
   // next state
   // ==================================================================
   always_comb begin
      s_d          = s_q;
      s_d.tx_go    = 1'b0;
      s_d.req_prev = req;
      s_d.wr_pend  = addr_ph && hwrite_i;
      if (addr_ph) begin
         s_d.addr = haddr_i[7:0];
      end
      if (rd_ph) begin
         s_d.rdata = rd_word;
      end
      // start strobe only while the receiver is enabled
      s_d.rx_go = s_q.ctrl.rx_on
         && (sync_mode_i ? rx_sclk_seen_i : rx_start_bit_i); // RULE_10 RULE_12
      if (s_q.wr_pend) begin
         unique case (s_q.addr)
            serial_ctl_pkg::CTRL_OFS: begin
               s_d.ctrl.rx_irq_on       =
                  hwdata_i[serial_ctl_pkg::RX_IRQ_ON_BIT];
               s_d.ctrl.tx_on           = hwdata_i[serial_ctl_pkg::TX_ON_BIT];
               s_d.ctrl.rx_on           = hwdata_i[serial_ctl_pkg::RX_ON_BIT];
               s_d.ctrl.rx_fault_irq_on =
                  hwdata_i[serial_ctl_pkg::RX_FAULT_IRQ_ON_BIT];
            end
            serial_ctl_pkg::IRQ_STS_OFS: begin
               s_d.irq_sts = s_q.irq_sts
                  & ~hwdata_i[serial_ctl_pkg::NUM_IRQ-1:0];
            end
            serial_ctl_pkg::IRQ_MSK_OFS: begin
               s_d.irq_msk = hwdata_i[serial_ctl_pkg::NUM_IRQ-1:0];
            end
            serial_ctl_pkg::TX_PORT_OFS: begin
               // data written while disabled is dropped, never queued
               if (s_q.ctrl.tx_on) begin                  // RULE_07
                  s_d.tx_data = hwdata_i[7:0];
                  s_d.tx_go   = 1'b1;                      // RULE_08
               end
            end
            default: begin
               s_d.ctrl = s_q.ctrl;
            end
         endcase
      end
      // a rising request sets its sticky bit; set beats the clear above
      s_d.irq_sts = s_d.irq_sts | (req & ~s_q.req_prev);
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q          <= '0;
         s_q.irq_sts  <= serial_ctl_pkg::IRQ_RST;
         s_q.irq_msk  <= serial_ctl_pkg::IRQ_RST;
         s_q.req_prev <= serial_ctl_pkg::IRQ_RST;
         s_q.tx_data  <= serial_ctl_pkg::TX_DATA_RST;
         s_q.rdata    <= serial_ctl_pkg::RDATA_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ==================================================================
   // outputs
   // ==================================================================
   assign hrdata_o    = s_q.rdata;
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign tx_on_o     = s_q.ctrl.tx_on;
   assign rx_on_o     = s_q.ctrl.rx_on;
   assign tx_start_o  = s_q.tx_go;
   assign tx_data_o   = s_q.tx_data;
   assign rx_start_o  = s_q.rx_go;

   // ==================================================================
   // assertions
   // ==================================================================
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   rxfull_gate_a: assert property ( // RULE_01
      rx_full_irq_o |-> s_q.ctrl.rx_irq_on
         && (flags[serial_ctl_pkg::F_TRIG] || flags[serial_ctl_pkg::F_IDLE]))
      else $error("receive-data request without enable or flag");

   fault_req_a: assert property ( // RULE_02
      (flags[serial_ctl_pkg::F_FAULT] && s_q.ctrl.rx_irq_on)
         |-> rx_fault_irq_o)
      else $error("fault request missing");

   break_req_a: assert property ( // RULE_03
      ($rose(flags[serial_ctl_pkg::F_OVERRUN]) && fault_en)
         |-> line_break_irq_o)
      else $error("break request missing on overrun");

   rxfull_drop_a: assert property ( // RULE_04
      (rx_full_irq_o && s_q.wr_pend && s_q.addr == serial_ctl_pkg::CTRL_OFS
         && !hwdata_i[serial_ctl_pkg::RX_IRQ_ON_BIT]) |=> !rx_full_irq_o)
      else $error("receive-data request kept after enable cleared");

   fault_off_a: assert property ( // RULE_05
      (!s_q.ctrl.rx_irq_on && !s_q.ctrl.rx_fault_irq_on)
         |-> !rx_fault_irq_o && !line_break_irq_o)
      else $error("fault or break request with both enables off");

   fault_only_a: assert property ( // RULE_06
      (!s_q.ctrl.rx_irq_on && s_q.ctrl.rx_fault_irq_on
         && flags[serial_ctl_pkg::F_BREAK]) |-> line_break_irq_o)
      else $error("fault enable alone did not pass break request");

   tx_gate_a: assert property ( // RULE_08
      tx_start_o |-> $past(tx_on_o) && $past(s_q.wr_pend)
         && $past(s_q.addr) == serial_ctl_pkg::TX_PORT_OFS)
      else $error("transmit start without tx port write");

   rx_gate_a: assert property ( // RULE_10
      rx_start_o |-> $past(rx_on_o))
      else $error("receive start while receiver off");

   flags_keep_a: assert property ( // RULE_11
      (s_q.wr_pend && s_q.addr == serial_ctl_pkg::CTRL_OFS
         && flag_set == '0) |=> $stable(flags))
      else $error("control write changed receive flags");

   rsvd_zero_a: assert property ( // RULE_14
      (rd_ph && haddr_i[7:0] == serial_ctl_pkg::CTRL_OFS)
         |=> hrdata_o[serial_ctl_pkg::CTRL_RSVD_BIT] == 1'b0)
      else $error("reserved control bit read as one");

   no_sw_set_a: assert property ( // RULE_15
      (flags & ~$past(flags) & ~$past(flag_set)) == '0)
      else $error("flag set without hardware event");

   req_hold_a: assert property ( // RULE_16
      (rx_fault_irq_o && !flag_clr[serial_ctl_pkg::F_FAULT]
         && !(s_q.wr_pend && s_q.addr == serial_ctl_pkg::CTRL_OFS))
         |=> rx_fault_irq_o)
      else $error("fault request dropped while conditions held");

   rxfull_seen_c: cover property (
      !rx_full_irq_o ##1 rx_full_irq_o ##[1:20] !rx_full_irq_o);
   fault_only_c: cover property (
      !s_q.ctrl.rx_irq_on && line_break_irq_o);
   tx_start_c: cover property (tx_start_o);
   irq_out_c: cover property ($rose(irq_o));
endmodule

// >>> serial_flag_cell.sv
// Purpose : shared constants and types, plus one sticky status flag that
//           clears only by a write of zero after it was read while set
// Assumes : one clock, asynchronous active-low reset, synchronous inputs
// Notes   : the flag cell is instantiated once per clearable status flag
`timescale 1ns/1ps

// =====================================================================
// package
// =====================================================================
package serial_ctl_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] STATUS_OFS   = 8'h04;
   localparam logic [7:0] LINE_OFS     = 8'h08;
   localparam logic [7:0] IRQ_STS_OFS  = 8'h0c;
   localparam logic [7:0] IRQ_MSK_OFS  = 8'h10;
   localparam logic [7:0] TX_PORT_OFS  = 8'h14;
   // control register bit positions
   localparam int RX_IRQ_ON_BIT        = 6;
   localparam int TX_ON_BIT            = 5;
   localparam int RX_ON_BIT            = 4;
   localparam int RX_FAULT_IRQ_ON_BIT  = 3;
   localparam int CTRL_RSVD_BIT        = 2;
   // status register bit positions
   localparam int FAULT_BIT            = 7;
   localparam int BREAK_BIT            = 4;
   localparam int FRAMING_BIT          = 3;
   localparam int PARITY_BIT           = 2;
   localparam int TRIGGER_BIT          = 1;
   localparam int IDLE_DATA_BIT        = 0;
   // line status register bit position
   localparam int OVERRUN_BIT          = 0;
   // clearable flag indices inside the flag vector
   localparam int NUM_FLAGS            = 5;
   localparam int F_IDLE               = 0;
   localparam int F_TRIG               = 1;
   localparam int F_BREAK              = 2;
   localparam int F_FAULT              = 3;
   localparam int F_OVERRUN            = 4;
   // interrupt status and mask bit positions
   localparam int NUM_IRQ              = 3;
   localparam int IRQ_RX_FULL          = 0;
   localparam int IRQ_RX_FAULT         = 1;
   localparam int IRQ_BREAK            = 2;
   // reset values
   localparam logic [2:0] IRQ_RST      = 3'h0;
   localparam logic [7:0] TX_DATA_RST  = 8'h00;
   localparam logic [31:0] RDATA_RST   = 32'h0000_0000;
   // ahb transfer type with the address-phase bit
   localparam int HTRANS_ACTIVE_BIT    = 1;

   typedef struct packed {
      logic flag;
      logic armed;
   } flag_state_t;

   typedef struct packed {
      logic rx_irq_on;
      logic tx_on;
      logic rx_on;
      logic rx_fault_irq_on;
   } ctrl_t;

   typedef struct packed {
      ctrl_t                 ctrl;
      logic [NUM_IRQ-1:0]    irq_sts;
      logic [NUM_IRQ-1:0]    irq_msk;
      logic [NUM_IRQ-1:0]    req_prev;
      logic                  wr_pend;
      logic [7:0]            addr;
      logic [31:0]           rdata;
      logic [7:0]            tx_data;
      logic                  tx_go;
      logic                  rx_go;
   } ctl_state_t;
endpackage

// =====================================================================
// sticky read-then-clear flag
// =====================================================================
module serial_flag_cell (
   // clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   // events
   input  wire logic set_i,
   input  wire logic rd_i,
   input  wire logic clr_i,
   // state
   output logic      flag_o
);
   serial_ctl_pkg::flag_state_t s_q;
   serial_ctl_pkg::flag_state_t s_d;

   // a set in the clearing cycle wins; a clear also consumes the arm,
   // so software must read the flag as set again before it clears
   always_comb begin
      s_d       = s_q;
      if (rd_i && s_q.flag) begin
         s_d.armed = 1'b1;
      end
      if (clr_i && s_q.armed) begin
         s_d.flag  = 1'b0;
         s_d.armed = 1'b0;
      end
      if (set_i) begin
         s_d.flag = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign flag_o = s_q.flag;
endmodule

// >>> serial_peer_model.sv
// Purpose : remote serial peer, reduced to the receiver events it causes
// Assumes : every event is a one-cycle pulse launched after a rising edge
// Notes   : framing and parity levels are held by the bench itself
`timescale 1ns/1ps

// =====================================================================
// peer model
// =====================================================================
module serial_peer_model (
   // clock
   input  wire logic       core_clk_i,
   // events: idle trig break fault overrun start_bit sclk
   output logic      [6:0] ev_o,
   // line mode
   output logic            sync_mode_o
);
   // quiet line until a scenario asks for traffic
   initial begin
      ev_o        = 7'h00;
      sync_mode_o = 1'b0;
   end

   // one event, exactly one clock long; k picks which of the seven event bits pulses
   task automatic fire(input int k);
      begin
         @(posedge core_clk_i);
         ev_o <= 7'h01 << k;
         @(posedge core_clk_i);
         ev_o <= 7'h00;
      end
   endtask

   // sync mode changes only between events
   task automatic mode(input logic s);
      begin
         sync_mode_o <= s;
      end
   endtask
endmodule

// >>> serial_enable_irq_tb_top.sv
// Purpose : self-checking bench for the serial enable and irq slice
// Assumes : zero-wait ahb-lite slave, registered read data
// Notes   : outputs other than read data are judged 1 ns after the edge so updates have landed
`timescale 1ns/1ps

// =====================================================================
// bench top
// =====================================================================
module serial_enable_irq_tb_top;
   logic        core_clk_i;
   logic        rst_n_i;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic [6:0]  ev;
   logic        sync_mode;
   logic        framing;
   logic        parity;
   logic        tx_on;
   logic        rx_on;
   logic        tx_start;
   logic [7:0]  tx_data;
   logic        rx_start;
   logic        rx_full_irq;
   logic        rx_fault_irq;
   logic        line_break_irq;
   logic        irq;
   int          num_errors;
   int          num_checks;
   int          tx_cnt;
   int          rx_cnt;

   serial_peer_model peer_u (.core_clk_i(core_clk_i), .ev_o(ev),
      .sync_mode_o(sync_mode));

   serial_enable_irq dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
      .hresp_o(), .rx_idle_data_set_i(ev[0]),
      .rx_fifo_trigger_set_i(ev[1]), .line_break_set_i(ev[2]),
      .rx_fault_set_i(ev[3]), .rx_overrun_set_i(ev[4]),
      .framing_fault_flag_i(framing), .parity_fault_flag_i(parity),
      .sync_mode_i(sync_mode), .rx_start_bit_i(ev[5]),
      .rx_sclk_seen_i(ev[6]), .tx_on_o(tx_on), .rx_on_o(rx_on),
      .tx_start_o(tx_start), .tx_data_o(tx_data), .rx_start_o(rx_start),
      .rx_full_irq_o(rx_full_irq), .rx_fault_irq_o(rx_fault_irq),
      .line_break_irq_o(line_break_irq), .irq_o(irq));

   // 125 mhz clock
   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end

   // start strobes are one-cycle pulses, so count them at every edge
   always @(posedge core_clk_i) begin
      if (tx_start === 1'b1) tx_cnt++;
      if (rx_start === 1'b1) rx_cnt++;
   end

   task automatic summarize();
      begin
         $display("errors %0d checks %0d", num_errors, num_checks);
         if (num_errors == 0 && num_checks > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      begin
         num_checks++;
         if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   // bounded wait for hready at a rising edge
   task automatic hwait();
      int n;
      begin
         @(posedge core_clk_i);
         for (n = 0; hreadyout !== 1'b1; n++) begin
            if (n == 20) begin
               num_errors++;
               summarize();
            end
            @(posedge core_clk_i);
         end
      end
   endtask

   // one single transfer; read data is taken before the edge's updates
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      begin
         hsel   <= 1'b1;
         htrans <= 2'h2;
         hwrite <= w;
         hsize  <= 3'h2;
         haddr  <= {24'h0, a};
         hwait();
         hsel   <= 1'b0;
         htrans <= 2'h0;
         hsize  <= 3'h0;
         hwdata <= d;
         hwait();
         q = hrdata;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      begin
         bus(1'b1, a, d, q);
         #1;
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      begin
         bus(1'b0, a, 32'h0, q);
         check(q, exp);
      end
   endtask

   task automatic idle(input int n);
      begin
         repeat (n) @(posedge core_clk_i);
         #1;
      end
   endtask

   // enables, reserved bit and an unmapped place
   task automatic t_ctrl();
      begin
         rd(8'h00, 32'h0);
         wr(8'h00, 32'h7c);
         rd(8'h00, 32'h78);
         check(32'(tx_on), 32'h1);
         check(32'(rx_on), 32'h1);
         rd(8'h18, 32'h0);
         wr(8'h00, 32'h0);
         check(32'(tx_on), 32'h0);
      end
   endtask

   // receive-data request, its gating and the read-then-clear path
   task automatic t_rx_full();
      begin
         peer_u.fire(1);
         #1;
         check(32'(rx_full_irq), 32'h0);
         wr(8'h00, 32'h40);
         check(32'(rx_full_irq), 32'h1);
         wr(8'h04, 32'h0);
         rd(8'h04, 32'h2);
         wr(8'h04, 32'hff);
         check(32'(rx_full_irq), 32'h1);
         wr(8'h04, 32'h0);
         check(32'(rx_full_irq), 32'h0);
         peer_u.fire(0);
         #1;
         check(32'(rx_full_irq), 32'h1);
         wr(8'h00, 32'h0);
         check(32'(rx_full_irq), 32'h0);
         rd(8'h04, 32'h1);
         wr(8'h04, 32'h0);
         rd(8'h04, 32'h0);
      end
   endtask

   // fault and break requests under both enables
   task automatic t_fault();
      begin
         wr(8'h00, 32'h08);
         peer_u.fire(3);
         peer_u.fire(2);
         #1;
         check(32'(rx_fault_irq), 32'h1);
         check(32'(line_break_irq), 32'h1);
         wr(8'h00, 32'h0);
         check(32'(rx_fault_irq), 32'h0);
         wr(8'h00, 32'h40);
         check(32'(rx_fault_irq), 32'h1);
         rd(8'h04, 32'h90);
         wr(8'h04, 32'h0);
         check(32'(rx_fault_irq), 32'h0);
         check(32'(line_break_irq), 32'h0);
         peer_u.fire(4);
         #1;
         check(32'(line_break_irq), 32'h1);
         rd(8'h08, 32'h1);
         wr(8'h08, 32'h0);
         check(32'(line_break_irq), 32'h0);
      end
   endtask

   // sticky status, mask and the shared output
   task automatic t_irq();
      begin
         check(32'(irq), 32'h0);
         rd(8'h0c, 32'h7);
         wr(8'h10, 32'h2);
         check(32'(irq), 32'h1);
         wr(8'h0c, 32'h2);
         check(32'(irq), 32'h0);
         wr(8'h0c, 32'h5);
         rd(8'h0c, 32'h0);
      end
   endtask

   // receiver enable, flags kept, start in both modes
   task automatic t_rx();
      begin
         wr(8'h00, 32'h10);
         peer_u.fire(3);
         framing <= 1'b1;
         parity  <= 1'b1;
         wr(8'h00, 32'h0);
         rd(8'h04, 32'h8c);
         wr(8'h04, 32'h0);
         framing <= 1'b0;
         parity  <= 1'b0;
         wr(8'h00, 32'h10);
         peer_u.fire(5);
         idle(2);
         check(32'(rx_cnt), 32'h1);
         peer_u.mode(1'b1);
         peer_u.fire(6);
         idle(2);
         check(32'(rx_cnt), 32'h2);
         wr(8'h00, 32'h0);
         peer_u.fire(6);
         idle(2);
         check(32'(rx_cnt), 32'h2);
      end
   endtask

   // transmit start only with the transmitter on and data written
   task automatic t_tx();
      begin
         wr(8'h14, 32'ha5);
         idle(2);
         check(32'(tx_cnt), 32'h0);
         wr(8'h00, 32'h20);
         idle(2);
         check(32'(tx_cnt), 32'h0);
         wr(8'h14, 32'h3c);
         idle(2);
         check(32'(tx_cnt), 32'h1);
         check(32'(tx_data), 32'h3c);
      end
   endtask

   // main sequence
   initial begin
      num_errors = 0;
      num_checks = 0;
      tx_cnt     = 0;
      rx_cnt     = 0;
      rst_n_i    = 1'b0;
      hsel       = 1'b0;
      haddr      = 32'h0;
      htrans     = 2'h0;
      hsize      = 3'h0;
      hwrite     = 1'b0;
      hwdata     = 32'h0;
      framing    = 1'b0;
      parity     = 1'b0;
      repeat (3) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      t_ctrl();
      t_rx_full();
      t_fault();
      t_irq();
      t_rx();
      t_tx();
      summarize();
   end
endmodule
